// File: rtl/tob_pkg.sv
package tob_pkg;

  // character grid geometry, sized for the larger of the two screens
  localparam int X_W = 7;
  localparam int Y_W = 6;
  localparam int ADDR_W = X_W + Y_W;
  localparam int CODE_W = 8;

  localparam logic [X_W-1:0] VGA_COLS = 7'h50;
  localparam logic [Y_W-1:0] VGA_ROWS = 6'h3c;
  localparam logic [X_W-1:0] LCD_COLS = 7'h32;
  localparam logic [Y_W-1:0] LCD_ROWS = 6'h1e;
  localparam logic [X_W-1:0] X_ZERO = 7'h00;
  localparam logic [Y_W-1:0] Y_ZERO = 6'h00;

  localparam logic [CODE_W-1:0] SPACE_CODE = 8'h20;
  localparam logic [CODE_W-1:0] PRINT_FIRST = 8'h21;
  localparam logic [CODE_W-1:0] PRINT_LAST = 8'h7e;

  // cell of 8 by 8 pixels; glyph rows and pixel columns share one width
  localparam int CELL_IDX_W = 3;
  localparam logic [CELL_IDX_W-1:0] CELL_FIRST = 3'h0;
  localparam logic [CELL_IDX_W-1:0] CELL_LAST = 3'h7;
  localparam int ROW_BITS_W = 8;

  // control port, byte offsets of the two registers
  localparam int CTRL_ADDR_W = 3;
  localparam int REG_W = 32;
  localparam logic [CTRL_ADDR_W-1:0] SCREEN_CONTROL_OFS = 3'h0;
  localparam logic [CTRL_ADDR_W-1:0] TEXT_GRID_SIZE_OFS = 3'h4;
  localparam int CLEAR_BIT = 16;
  localparam int COLS_LSB = 0;
  localparam int LINES_LSB = 16;

  // longest allowed full clear
  localparam int CLEAR_MAX_CYCLES = 5000;

  // 40-bit pixel: alpha, red, green, blue of 10 bits each
  localparam int COMP_W = 10;
  localparam int PIX_W = 4 * COMP_W;
  localparam logic [COMP_W-1:0] COMP_FULL = 10'h3ff;
  localparam logic [COMP_W-1:0] COMP_NONE = 10'h000;

  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_LOOK = 2'b01,
    ST_LOAD = 2'b10,
    ST_EMIT = 2'b11
  } tob_rd_state_e;

  // glyph pixel white, anything else transparent (or black without alpha)
  function automatic logic [PIX_W-1:0] pixel_of(input logic on,
                                                input logic transp);
    logic [COMP_W-1:0] colour;
    logic [COMP_W-1:0] alpha;
    colour = on ? COMP_FULL : COMP_NONE;
    alpha = (on && transp) ? COMP_FULL : COMP_NONE;
    return {alpha, colour, colour, colour};
  endfunction

endpackage

// File: rtl/tob_char_mem.sv
module tob_char_mem
  import tob_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = CODE_W
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_a_addr_i,
  output logic [DW-1:0] rd_a_data_o,
  input wire logic [AW-1:0] rd_b_addr_i,
  output logic [DW-1:0] rd_b_data_o
);

  // array itself is not reset; the clear sweep fills the visible grid cells after reset
  logic [DW-1:0] cells [0:(1<<AW)-1];

  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      cells[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_a_data_o <= '0;
      rd_b_data_o <= '0;
    end else begin
      rd_a_data_o <= cells[rd_a_addr_i];
      rd_b_data_o <= cells[rd_b_addr_i];
    end
  end

endmodule // tob_char_mem

// File: rtl/tob_glyph_rom.sv
module tob_glyph_rom
  import tob_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [CODE_W-1:0] code_i,
  input wire logic [CELL_IDX_W-1:0] row_i,
  output logic [ROW_BITS_W-1:0] row_bits_o
);

  // one byte per glyph row, top row first, 5 pixel columns in bits 4..0
  // hex digits are drawn; other printable codes show a box outline
  function automatic logic [63:0] font_of(input logic [CODE_W-1:0] c);
    unique case (c)
      8'h30: return 64'h0e11_1315_1911_0e00;
      8'h31: return 64'h040c_0404_0404_0e00;
      8'h32: return 64'h0e11_0102_0408_1f00;
      8'h33: return 64'h1f02_0402_0111_0e00;
      8'h34: return 64'h0206_0a12_1f02_0200;
      8'h35: return 64'h1f10_1e01_0111_0e00;
      8'h36: return 64'h0608_101e_1111_0e00;
      8'h37: return 64'h1f01_0204_0808_0800;
      8'h38: return 64'h0e11_110e_1111_0e00;
      8'h39: return 64'h0e11_110f_0102_0c00;
      8'h41: return 64'h0e11_111f_1111_1100;
      8'h42: return 64'h1e11_111e_1111_1e00;
      8'h43: return 64'h0e11_1010_1011_0e00;
      8'h44: return 64'h1c12_1111_1112_1c00;
      8'h45: return 64'h1f10_101e_1010_1f00;
      8'h46: return 64'h1f10_101e_1010_1000;
      default: begin
        if (c >= PRINT_FIRST && c <= PRINT_LAST) begin
          return 64'h1f11_1111_1111_1f00;
        end
        return 64'h0000_0000_0000_0000;
      end
    endcase
  endfunction

  logic [63:0] font_word;
  logic [5:0] shift_amt;
  logic [7:0] font_row;
  logic [ROW_BITS_W-1:0] next_row_bits;

  assign font_word = font_of(code_i);
  assign shift_amt = {CELL_LAST - row_i, 3'h0};
  assign font_row = 8'(font_word >> shift_amt);
  // glyph sits in pixel columns 1..5, leftmost pixel in the msb
  assign next_row_bits = {1'b0, font_row[4:0], 2'b00};

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      row_bits_o <= '0;
    end else begin
      row_bits_o <= next_row_bits;
    end
  end

endmodule // tob_glyph_rom

// File: rtl/tob_text_overlay.sv
// What this block does
// R1 - render stored codes as glyph pixels and stream them out
// R2 - host character writes are kept in on-chip character memory
// R3 - own reader fetches codes for the renderer, apart from host access
// R4 - glyph pixels white, every other pixel transparent
// R5 - reset or init fills every cell with the space code
// R6 - a full clear ends within 5000 clock cycles
// R7 - vga build uses 80 characters by 60 lines
// R8 - lcd build uses 50 characters by 30 lines
// R9 - cells addressed only by separate column and row fields
// R10 - character port is one byte, one code per access
// R11 - transparency build streams 40-bit rgba pixels
// R12 - writing one to control bit 16 starts a full clear
// R13 - clear bit reads one while clearing, drops to zero by itself
// R14 - grid register: columns in bits 15-0, lines in bits 31-16
// R15 - software writes zero to reserved control bits; reads undefined
// R16 - pixel is four 10-bit planes: alpha, red, green, blue
// R17 - one packet per frame, row-major, sop first, eop last pixel
// R18 - character address is row field above column field
// R19 - pixel held stable until the sink is ready
// R20 - out of range host writes are dropped
module tob_text_overlay
  import tob_pkg::*;
#(
  parameter bit LCD_MODE = 1'b0,
  parameter bit TRANSPARENT = 1'b1
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [ADDR_W-1:0] char_addr_i,
  input wire logic char_write_i,
  input wire logic [CODE_W-1:0] char_writedata_i,
  input wire logic char_read_i,
  output logic [CODE_W-1:0] char_readdata_o,
  output logic char_readvalid_o,
  input wire logic [CTRL_ADDR_W-1:0] ctrl_addr_i,
  input wire logic ctrl_write_i,
  input wire logic [REG_W-1:0] ctrl_writedata_i,
  input wire logic ctrl_read_i,
  output logic [REG_W-1:0] ctrl_readdata_o,
  output logic [PIX_W-1:0] pix_data_o,
  output logic pix_valid_o,
  output logic pix_sop_o,
  output logic pix_eop_o,
  input wire logic pix_ready_i
);

  localparam logic [X_W-1:0] COLS = LCD_MODE ? LCD_COLS : VGA_COLS; // R7 R8
  localparam logic [Y_W-1:0] ROWS = LCD_MODE ? LCD_ROWS : VGA_ROWS; // R7 R8
  localparam logic [X_W-1:0] COLS_M1 = COLS - 1'b1;
  localparam logic [Y_W-1:0] ROWS_M1 = ROWS - 1'b1;


  // host character port

  logic [X_W-1:0] host_x;
  logic [Y_W-1:0] host_y;
  logic host_in_range;
  logic host_wr;
  logic read_oob;
  logic read_pending;
  logic [CODE_W-1:0] mem_b_data;

  assign host_x = char_addr_i[X_W-1:0]; // R9 R18
  assign host_y = char_addr_i[ADDR_W-1 -: Y_W]; // R9 R18
  assign host_in_range = (host_x < COLS) && (host_y < ROWS); // R20

  // host writes lose to the clear sweep so the screen really ends blank
  logic clearing;
  assign host_wr = char_write_i && host_in_range && !clearing; // R20

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      read_pending <= 1'b0;
      read_oob <= 1'b0;
    end else begin
      read_pending <= char_read_i;
      read_oob <= !host_in_range;
    end
  end

  // out of range reads answer zero instead of whatever the cell holds
  assign char_readvalid_o = read_pending;
  assign char_readdata_o = (read_pending && !read_oob) ? mem_b_data : '0;


  // clear sweep: one cell per cycle over the visible grid only, which
  // keeps the worst case at 4800 cycles for the larger screen

  logic [X_W-1:0] clr_x;
  logic [Y_W-1:0] clr_y;
  logic clr_last;
  logic clear_req;
  logic next_clearing;
  logic [X_W-1:0] next_clr_x;
  logic [Y_W-1:0] next_clr_y;

  assign clr_last = (clr_x == COLS_M1) && (clr_y == ROWS_M1); // R6
  assign clear_req = ctrl_write_i && (ctrl_addr_i == SCREEN_CONTROL_OFS)
                     && ctrl_writedata_i[CLEAR_BIT]; // R12

  // a fresh request in the last sweep cycle restarts the sweep
  assign next_clearing = clear_req ? 1'b1 : (clearing && !clr_last); // R13

  always_comb begin
    next_clr_x = clr_x;
    next_clr_y = clr_y;
    if (clear_req && !clearing) begin
      next_clr_x = X_ZERO;
      next_clr_y = Y_ZERO;
    end else if (clearing) begin
      if (clr_x == COLS_M1) begin
        next_clr_x = X_ZERO;
        next_clr_y = (clr_y == ROWS_M1) ? Y_ZERO : clr_y + 1'b1;
      end else begin
        next_clr_x = clr_x + 1'b1;
      end
    end
  end

  // reset leaves the sweep running from cell zero
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clearing <= 1'b1; // R5
      clr_x <= X_ZERO;
      clr_y <= Y_ZERO;
    end else begin
      clearing <= next_clearing; // R13
      clr_x <= next_clr_x;
      clr_y <= next_clr_y;
    end
  end

  // single write port: the sweep owns it while clearing
  logic mem_wr_en;
  logic [ADDR_W-1:0] mem_wr_addr;
  logic [CODE_W-1:0] mem_wr_data;

  assign mem_wr_en = clearing || host_wr; // R2
  assign mem_wr_addr = clearing ? {clr_y, clr_x} : char_addr_i; // R5 R18
  assign mem_wr_data = clearing ? SPACE_CODE : char_writedata_i; // R5 R10


  // control port

  logic [REG_W-1:0] control_word;
  logic [REG_W-1:0] grid_word;
  logic [REG_W-1:0] next_ctrl_rdata;

  // reserved bits answer zero
  assign control_word = REG_W'(clearing) << CLEAR_BIT; // R13 R15
  assign grid_word = (REG_W'(ROWS) << LINES_LSB)
                     | (REG_W'(COLS) << COLS_LSB); // R14

  assign next_ctrl_rdata =
    (ctrl_addr_i == SCREEN_CONTROL_OFS) ? control_word :
    (ctrl_addr_i == TEXT_GRID_SIZE_OFS) ? grid_word : '0;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_readdata_o <= '0;
    end else if (ctrl_read_i) begin
      ctrl_readdata_o <= next_ctrl_rdata;
    end
  end


  // reader and renderer: per cell and glyph row, fetch the code, look
  // up the row bits, then emit eight pixels; gaps between cells cost
  // three cycles, traded for a design with no line buffer

  tob_rd_state_e state;
  tob_rd_state_e next_state;
  logic [X_W-1:0] cell_x;
  logic [Y_W-1:0] cell_y;
  logic [CELL_IDX_W-1:0] g_row;
  logic [CELL_IDX_W-1:0] bit_idx;
  logic [ROW_BITS_W-1:0] row_q;
  logic [ROW_BITS_W-1:0] rom_row;
  logic [CODE_W-1:0] mem_a_data;
  logic [PIX_W-1:0] pix_q;
  logic sop_q;
  logic eop_q;

  logic take;
  logic cell_done;
  logic frame_last_cell;
  logic frame_first_cell;
  logic [CELL_IDX_W-1:0] next_bit;
  logic [X_W-1:0] adv_x;
  logic [Y_W-1:0] adv_y;
  logic [CELL_IDX_W-1:0] adv_row;

  assign take = (state == ST_EMIT) && pix_ready_i; // R19
  assign cell_done = take && (bit_idx == CELL_LAST);
  assign next_bit = bit_idx + 1'b1;
  assign frame_first_cell = (cell_x == X_ZERO) && (cell_y == Y_ZERO)
                            && (g_row == CELL_FIRST); // R17
  assign frame_last_cell = (cell_x == COLS_M1) && (cell_y == ROWS_M1)
                           && (g_row == CELL_LAST); // R17

  // row-major walk: across a pixel line cell by cell, then down
  always_comb begin
    adv_x = cell_x + 1'b1;
    adv_y = cell_y;
    adv_row = g_row;
    if (cell_x == COLS_M1) begin
      adv_x = X_ZERO;
      if (g_row == CELL_LAST) begin
        adv_row = CELL_FIRST;
        adv_y = (cell_y == ROWS_M1) ? Y_ZERO : cell_y + 1'b1;
      end else begin
        adv_row = g_row + 1'b1;
      end
    end
  end // R17

  always_comb begin
    next_state = state;
    unique case (state)
      ST_FETCH: next_state = ST_LOOK; // R3
      ST_LOOK: next_state = ST_LOAD;
      ST_LOAD: next_state = ST_EMIT;
      ST_EMIT: next_state = cell_done ? ST_FETCH : ST_EMIT; // R19
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ST_FETCH;
      cell_x <= X_ZERO;
      cell_y <= Y_ZERO;
      g_row <= CELL_FIRST;
    end else begin
      state <= next_state;
      if (cell_done) begin
        cell_x <= adv_x;
        cell_y <= adv_y;
        g_row <= adv_row;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_idx <= CELL_FIRST;
      row_q <= '0;
      pix_q <= '0;
      sop_q <= 1'b0;
      eop_q <= 1'b0;
    end else if (state == ST_LOAD) begin
      bit_idx <= CELL_FIRST;
      row_q <= rom_row;
      pix_q <= pixel_of(rom_row[ROW_BITS_W-1], TRANSPARENT); // R1 R4 R11
      sop_q <= frame_first_cell; // R17
      eop_q <= 1'b0;
    end else if (take && !cell_done) begin
      bit_idx <= next_bit;
      pix_q <= pixel_of(row_q[CELL_LAST - next_bit], TRANSPARENT); // R1
      sop_q <= 1'b0;
      eop_q <= frame_last_cell && (next_bit == CELL_LAST); // R17
    end else if (cell_done) begin
      bit_idx <= CELL_FIRST;
    end
  end

  // pixel planes go out as alpha, red, green, blue
  assign pix_data_o = pix_q; // R16
  assign pix_valid_o = (state == ST_EMIT);
  assign pix_sop_o = sop_q && pix_valid_o; // R17
  assign pix_eop_o = eop_q && pix_valid_o; // R17


  // storage and glyph lookup

  tob_char_mem #(
    .AW(ADDR_W),
    .DW(CODE_W)
  ) u_mem (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .wr_en_i(mem_wr_en),
    .wr_addr_i(mem_wr_addr),
    .wr_data_i(mem_wr_data),
    .rd_a_addr_i({cell_y, cell_x}),
    .rd_a_data_o(mem_a_data),
    .rd_b_addr_i(char_addr_i),
    .rd_b_data_o(mem_b_data)
  ); // R2 R3

  tob_glyph_rom u_rom (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .code_i(mem_a_data),
    .row_i(g_row),
    .row_bits_o(rom_row)
  ); // R1

endmodule // tob_text_overlay

// File: sim/tob_text_overlay_asserts.sv
module tob_text_overlay_chk
  import tob_pkg::*;
#(
  parameter bit LCD_MODE = 1'b0,
  parameter bit TRANSPARENT = 1'b1
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic char_read_i,
  input wire logic [CODE_W-1:0] char_readdata_o,
  input wire logic char_readvalid_o,
  input wire logic [CTRL_ADDR_W-1:0] ctrl_addr_i,
  input wire logic ctrl_write_i,
  input wire logic [REG_W-1:0] ctrl_writedata_i,
  input wire logic ctrl_read_i,
  input wire logic [REG_W-1:0] ctrl_readdata_o,
  input wire logic [PIX_W-1:0] pix_data_o,
  input wire logic pix_valid_o,
  input wire logic pix_sop_o,
  input wire logic pix_eop_o,
  input wire logic pix_ready_i
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [REG_W-1:0] GRID = LCD_MODE ?
    {10'h000, LCD_ROWS, 9'h000, LCD_COLS} :
    {10'h000, VGA_ROWS, 9'h000, VGA_COLS};
  localparam logic [PIX_W-1:0] PIX_ON = TRANSPARENT ?
    {4{COMP_FULL}} : {COMP_NONE, {3{COMP_FULL}}};
  wire logic clr_req;
  wire logic ctl_rd;
  logic [12:0] since_clr;
  assign clr_req = ctrl_write_i && ctrl_addr_i == SCREEN_CONTROL_OFS &&
                   ctrl_writedata_i[CLEAR_BIT];
  assign ctl_rd = ctrl_read_i && ctrl_addr_i == SCREEN_CONTROL_OFS;
  // saturates so a long run never wraps back under the bound
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) since_clr <= 13'h0000;
    else if (clr_req) since_clr <= 13'h0000;
    else if (since_clr != 13'h1fff) since_clr <= since_clr + 13'h0001;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  property p_rd_ans; char_readvalid_o == $past(char_read_i); endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read answer timing");
  property p_rd_idle; !char_readvalid_o |-> char_readdata_o == '0; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data without valid");
  property p_hold;
    pix_valid_o && !pix_ready_i |=> pix_valid_o && $stable(pix_data_o) &&
      $stable(pix_sop_o) && $stable(pix_eop_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pixel changed while stalled");
  // pixels before the sweep ends may come from unknown memory
  property p_pix;
    pix_valid_o && since_clr > CLEAR_MAX_CYCLES |->
      (pix_data_o == PIX_ON || pix_data_o == '0);
  endproperty
  a_pix: assert property (p_pix)
    else $error("pixel neither glyph nor clear");
  property p_grid; ctrl_read_i && ctrl_addr_i == TEXT_GRID_SIZE_OFS
    |=> ctrl_readdata_o == GRID; endproperty
  a_grid: assert property (p_grid)
    else $error("grid size wrong");
  property p_clr_set; clr_req ##[1:3] ctl_rd |=> ctrl_readdata_o[CLEAR_BIT];
  endproperty
  a_clr_set: assert property (p_clr_set)
    else $error("clear bit not set");
  property p_clr_bound; ctl_rd && since_clr > CLEAR_MAX_CYCLES
    |=> !ctrl_readdata_o[CLEAR_BIT]; endproperty
  a_clr_bound: assert property (p_clr_bound)
    else $error("clear too long");
  property p_rsv; ctl_rd |=> ctrl_readdata_o[31:17] == '0 &&
    ctrl_readdata_o[15:0] == '0; endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved bits set");
  property p_sop; pix_valid_o && pix_sop_o |-> !pix_eop_o; endproperty
  a_sop: assert property (p_sop)
    else $error("sop and eop together");
  // counts taken pixels so eop can be held against the frame size
  localparam int FRAME_LAST = LCD_MODE ?
    int'(LCD_COLS) * int'(LCD_ROWS) * 64 - 1 :
    int'(VGA_COLS) * int'(VGA_ROWS) * 64 - 1;
  int pix_idx;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pix_idx <= 0;
    end else if (pix_valid_o && pix_ready_i) begin
      pix_idx <= pix_sop_o ? 1 : pix_idx + 1;
    end
  end
  property p_eop; pix_valid_o && !pix_sop_o |->
    pix_eop_o == (pix_idx == FRAME_LAST); endproperty
  a_eop: assert property (p_eop)
    else $error("eop misplaced");
  c_stall: cover property (pix_valid_o && !pix_ready_i);
  c_clr: cover property (clr_req);
  c_lit: cover property (pix_valid_o && pix_data_o == PIX_ON);
endmodule // tob_text_overlay_chk

bind tob_text_overlay tob_text_overlay_chk #(
  .LCD_MODE(LCD_MODE), .TRANSPARENT(TRANSPARENT)
) i_chk (
  .clock_i(clock_i), .nrst_i(nrst_i), .char_read_i(char_read_i),
  .char_readdata_o(char_readdata_o), .char_readvalid_o(char_readvalid_o),
  .ctrl_addr_i(ctrl_addr_i), .ctrl_write_i(ctrl_write_i),
  .ctrl_writedata_i(ctrl_writedata_i), .ctrl_read_i(ctrl_read_i),
  .ctrl_readdata_o(ctrl_readdata_o), .pix_data_o(pix_data_o),
  .pix_valid_o(pix_valid_o), .pix_sop_o(pix_sop_o),
  .pix_eop_o(pix_eop_o), .pix_ready_i(pix_ready_i)
);

// File: sim/tob_sink.sv
module tob_sink
  import tob_pkg::*;
#(
  parameter int COLS = 50
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [PIX_W-1:0] pix_data_i,
  input wire logic pix_valid_i,
  input wire logic pix_sop_i,
  output logic pix_ready_o,
  output int pix_n_o,
  output int stray_o,
  output int lit_o [4]
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase;
  // ready low one cycle in three so the source must hold its pixel
  assign pix_ready_o = (phase != 2'h0);
  always @(posedge clock_i or negedge nrst_i) begin : take
    int idx;
    int ln;
    int cl;
    if (!nrst_i) begin
      phase <= 2'h0;
      pix_n_o <= 0;
      stray_o <= 0;
      lit_o <= '{default: 0};
    end else begin
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      if (pix_valid_i && pix_ready_o) begin
        idx = pix_sop_i ? 0 : pix_n_o;
        ln = idx / (COLS * 8);
        cl = idx % (COLS * 8);
        pix_n_o <= idx + 1;
        // only text row 1 is judged: it is drawn after the sweep ends
        if (pix_data_i != '0 && ln / 8 == 1) begin
          if (cl / 8 < 4) lit_o[cl / 8] <= lit_o[cl / 8] + 1;
          if (cl % 8 == 0 || cl % 8 > 5 || ln % 8 == 7) begin
            stray_o <= stray_o + 1;
          end
        end
      end
    end
  end
endmodule // tob_sink

// File: sim/tob_text_overlay_bench.sv
module tob_text_overlay_bench
  import tob_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [REG_W-1:0] GRID = {10'h000, LCD_ROWS, 9'h000, LCD_COLS};
  localparam logic [REG_W-1:0] CLR = 32'h0001_0000;
  localparam logic [REG_W-1:0] VGA_GRID =
    {10'h000, VGA_ROWS, 9'h000, VGA_COLS};
  logic [REG_W-1:0] v_rdata;
  logic clock_i;
  logic nrst_i = 1'b0;
  logic [ADDR_W-1:0] c_addr = '0;
  logic c_wr = 1'b0;
  logic c_rd = 1'b0;
  logic [CODE_W-1:0] c_data = '0;
  logic [CODE_W-1:0] c_rdata;
  logic c_rv;
  logic [CTRL_ADDR_W-1:0] k_addr = '0;
  logic k_wr = 1'b0;
  logic k_rd = 1'b0;
  logic [REG_W-1:0] k_data = '0;
  logic [REG_W-1:0] k_rdata;
  logic [PIX_W-1:0] px;
  logic pv, ps, pe, pr;
  int fails = 0;
  int compares = 0;
  int pix_n, stray, n;
  int lit [4];

  tob_text_overlay #(.LCD_MODE(1'b1), .TRANSPARENT(1'b1)) i_dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .char_addr_i(c_addr),
    .char_write_i(c_wr), .char_writedata_i(c_data), .char_read_i(c_rd),
    .char_readdata_o(c_rdata), .char_readvalid_o(c_rv),
    .ctrl_addr_i(k_addr), .ctrl_write_i(k_wr), .ctrl_writedata_i(k_data),
    .ctrl_read_i(k_rd), .ctrl_readdata_o(k_rdata), .pix_data_o(px),
    .pix_valid_o(pv), .pix_sop_o(ps), .pix_eop_o(pe), .pix_ready_i(pr)
  );
  // second build shares all stimulus; the bench compares only its register answers, the bound checker judges its streams
  tob_text_overlay #(.LCD_MODE(1'b0), .TRANSPARENT(1'b0)) i_dut_vga (
    .clock_i(clock_i), .nrst_i(nrst_i), .char_addr_i(c_addr),
    .char_write_i(c_wr), .char_writedata_i(c_data), .char_read_i(c_rd),
    .char_readdata_o(), .char_readvalid_o(),
    .ctrl_addr_i(k_addr), .ctrl_write_i(k_wr), .ctrl_writedata_i(k_data),
    .ctrl_read_i(k_rd), .ctrl_readdata_o(v_rdata), .pix_data_o(),
    .pix_valid_o(), .pix_sop_o(), .pix_eop_o(), .pix_ready_i(pr)
  );
  tob_sink #(.COLS(50)) i_sink (
    .clock_i(clock_i), .nrst_i(nrst_i), .pix_data_i(px), .pix_valid_i(pv),
    .pix_sop_i(ps), .pix_ready_o(pr), .pix_n_o(pix_n), .stray_o(stray),
    .lit_o(lit)
  );

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  function automatic logic [ADDR_W-1:0] ca(input int x, input int y);
    return {y[Y_W-1:0], x[X_W-1:0]};
  endfunction
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cw(input int x, input int y, input logic [7:0] d);
    @(negedge clock_i);
    c_addr = ca(x, y);
    c_data = d;
    c_wr = 1'b1;
    @(negedge clock_i);
    c_wr = 1'b0;
  endtask
  task automatic cr(input int x, input int y, input logic [7:0] e);
    @(negedge clock_i);
    c_addr = ca(x, y);
    c_rd = 1'b1;
    @(negedge clock_i);
    c_rd = 1'b0;
    chk(c_rv, 1'b1);
    chk(c_rdata, e);
  endtask
  task automatic kw(input logic [2:0] a, input logic [31:0] d);
    @(negedge clock_i);
    k_addr = a;
    k_data = d;
    k_wr = 1'b1;
    @(negedge clock_i);
    k_wr = 1'b0;
  endtask
  task automatic kr(input logic [2:0] a, input logic [31:0] e);
    @(negedge clock_i);
    k_addr = a;
    k_rd = 1'b1;
    @(negedge clock_i);
    k_rd = 1'b0;
    chk(k_rdata, e);
  endtask
  // polls the clear bit; n is the cycles spent, two per read
  task automatic wait_clr(output int n);
    n = 0;
    k_addr = SCREEN_CONTROL_OFS;
    while (n < 6000) begin
      @(negedge clock_i);
      k_rd = 1'b1;
      @(negedge clock_i);
      k_rd = 1'b0;
      n += 2;
      if (k_rdata[CLEAR_BIT] === 1'b0) break;
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #(60000 * 100);
    fails++;
    print_verdict();
  end

  initial begin
    repeat (5) @(negedge clock_i);
    nrst_i = 1'b1;
    kr(SCREEN_CONTROL_OFS, CLR);
    chk(v_rdata, CLR);
    kr(TEXT_GRID_SIZE_OFS, GRID);
    chk(v_rdata, VGA_GRID);
    kr(3'h2, 32'h0000_0000);
    cw(5, 5, 8'h41);
    wait_clr(n);
    chk(n <= CLEAR_MAX_CYCLES, 1'b1);
    cr(5, 5, SPACE_CODE);
    cr(49, 29, SPACE_CODE);
    cw(1, 1, 8'h30);
    cw(2, 1, 8'h23);
    cw(3, 1, 8'h41);
    cw(3, 1, SPACE_CODE);
    cw(49, 0, PRINT_LAST);
    cr(1, 1, 8'h30);
    cr(49, 0, PRINT_LAST);
    // a wrapping decode would land both of these on valid cells, a linear decode only the first
    cw(50, 1, 8'h23);
    cw(0, 30, 8'h23);
    cr(0, 2, SPACE_CODE);
    cr(0, 0, SPACE_CODE);
    cr(50, 1, 8'h00);
    for (int i = 0; i < 30000 && pix_n < 6400; i++) @(negedge clock_i);
    chk(pix_n >= 6400, 1'b1);
    chk(lit[0], 0);
    chk(lit[1] != 0, 1'b1);
    chk(lit[2] != 0, 1'b1);
    chk(lit[3], 0);
    chk(stray, 0);
    kr(SCREEN_CONTROL_OFS, 32'h0000_0000);
    chk(v_rdata, 32'h0000_0000);
    kw(TEXT_GRID_SIZE_OFS, 32'h0000_0000);
    kr(TEXT_GRID_SIZE_OFS, GRID);
    kw(SCREEN_CONTROL_OFS, 32'h0000_0000);
    kr(SCREEN_CONTROL_OFS, 32'h0000_0000);
    kw(SCREEN_CONTROL_OFS, CLR);
    kr(SCREEN_CONTROL_OFS, CLR);
    cw(6, 6, 8'h41);
    wait_clr(n);
    chk(n <= CLEAR_MAX_CYCLES, 1'b1);
    cr(1, 1, SPACE_CODE);
    cr(6, 6, SPACE_CODE);
    print_verdict();
  end
endmodule // tob_text_overlay_bench
